// *** src/sdmc_pkg.sv ***
// Package for the SD mode configuration register bank.
// Assumes an 8-bit sub-address register port from the serial MPU interface.
package sdmc_pkg;
    localparam logic [7:0] ADDR_STD_FILTER = 8'h80;
    localparam logic [7:0] ADDR_OUT_OPTION = 8'h82;
    localparam logic [7:0] ADDR_LVL_VBI_CC = 8'h83;
    localparam logic [7:0] RST_STD_FILTER = 8'h10;
    localparam logic [7:0] RST_OUT_OPTION = 8'h0B;
    localparam logic [7:0] RST_LVL_VBI_CC = 8'h04;
    localparam logic [7:0] MASK_LVL_VBI_CC = 8'h7F;
    localparam int NUM_REGS = 3;
    // Register 0x80 fields
    localparam int POS_STANDARD = 0;
    localparam int POS_LUMA_FILT = 2;
    localparam int POS_CHROMA_FILT = 5;
    // Register 0x82 fields
    localparam int POS_PRPB_AAF = 0;
    localparam int POS_DAC_OUT1 = 1;
    localparam int POS_DAC_OUT2 = 2;
    localparam int POS_SETUP = 3;
    localparam int POS_SQUARE_PIX = 4;
    localparam int POS_TRICK_SYNC = 5;
    localparam int POS_PIX_VALID = 6;
    localparam int POS_EDGE_CTRL = 7;
    // Register 0x83 fields
    localparam int POS_YPRPB_PED = 0;
    localparam int POS_Y_LEVEL = 1;
    localparam int POS_PRPB_LEVEL = 2;
    localparam int POS_VBI_PASS = 4;
    localparam int POS_CC_FIELD = 5;
    // Caption field codes
    localparam logic [1:0] CC_OFF = 2'h0;
    localparam logic [1:0] CC_ODD = 2'h1;
    localparam logic [1:0] CC_EVEN = 2'h2;
    localparam logic [1:0] CC_BOTH = 2'h3;
    // Colour-difference swing codes
    localparam logic [1:0] LVL_BY_STD = 2'h0;
    localparam logic [1:0] LVL_700 = 2'h1;
    localparam logic [1:0] LVL_1000 = 2'h2;
    localparam logic [1:0] LVL_648 = 2'h3;
    localparam logic [1:0] STD_NTSC = 2'h0;

    typedef struct packed {
        logic [1:0] standard;
        logic [2:0] luma_filter;
        logic [2:0] chroma_filter;
        logic prpb_antialias;
        logic dac_out1;
        logic dac_out2;
        logic composite_setup_offset;
        logic square_pixel;
        logic tape_trick_play_sync;
        logic pixel_valid_en;
        logic edge_ctrl_en;
        logic yprpb_pedestal;
        logic y_level_714;
        logic [1:0] prpb_level;
        logic prpb_swing_1000;
        logic blanking_interval_passthrough;
        logic caption_insert;
    } sdmc_cfg_t;
endpackage : sdmc_pkg

// *** src/sdmc_reg_mem.sv ***
// Small register store for the SD mode bank, registered read data.
// Assumes single-cycle write strobe and index already decoded.
`timescale 1ns/10ps
module sdmc_reg_mem (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [1:0] wr_idx_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [1:0] rd_idx_i,
    output logic [7:0] rd_data_o,
    output logic [23:0] all_o
);
    typedef struct packed {
        logic [2:0][7:0] mem;
        logic [7:0] rd_data;
    } sdmc_mem_state_t;

    sdmc_mem_state_t state;
    sdmc_mem_state_t next_state;

    always_comb begin
        next_state = state;
        if (wr_en_i && wr_idx_i < 2'h3) begin
            next_state.mem[wr_idx_i] = wr_data_i;
        end
        // Index 3 is unmapped and reads zero
        next_state.rd_data = (rd_idx_i < 2'h3) ? state.mem[rd_idx_i] : 8'h00;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state.mem <= {sdmc_pkg::RST_LVL_VBI_CC, sdmc_pkg::RST_OUT_OPTION, sdmc_pkg::RST_STD_FILTER};
            state.rd_data <= 8'h00;
        end else begin
            state <= next_state;
        end
    end

    assign rd_data_o = state.rd_data;
    assign all_o = state.mem;
endmodule : sdmc_reg_mem

// *** src/sdmc_regs.sv ***
// SD mode configuration register bank (sub-addresses 0x80, 0x82, 0x83).
// Assumes the serial MPU port delivers decoded sub-address, data and strobes
// synchronous to ref_clk_i; field_odd_i comes from the timing generator.
`timescale 1ns/10ps
// Notes on behaviour
// R1 - Caption field bits 6:5: off, odd only, even only, both fields.
// R2 - Register 0x83 bit 0 adds 7.5 IRE pedestal on component outputs.
// R3 - Colour-difference swing: by standard, 700, 1000 or 648 mV p-p.
// R4 - Register 0x82 bit 4 selects square-pixel timing, else normal timing.
// R5 - Register 0x82 bit 6 enables pixel-data-valid handling; off after reset.
// R6 - Register 0x82 bit 7 enables active-video edge shaping.
// R7 - Software avoids reserved filter codes and reserved top bit of 0x83.
module sdmc_regs (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] sub_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic field_odd_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output sdmc_pkg::sdmc_cfg_t cfg_o
);
    typedef struct packed {
        logic rd_valid;
        sdmc_pkg::sdmc_cfg_t cfg;
    } sdmc_state_t;

    sdmc_state_t state;
    sdmc_state_t next_state;
    logic [23:0] regs;
    logic [7:0] mem_rd;
    logic [1:0] wr_idx;
    logic [1:0] rd_idx;
    logic [7:0] wr_val;
    logic [7:0] r0;
    logic [7:0] r2;
    logic [7:0] r3;

    function automatic logic [1:0] addr_index(input logic [7:0] a);
        case (a)
            sdmc_pkg::ADDR_STD_FILTER: addr_index = 2'h0;
            sdmc_pkg::ADDR_OUT_OPTION: addr_index = 2'h1;
            sdmc_pkg::ADDR_LVL_VBI_CC: addr_index = 2'h2;
            default: addr_index = 2'h3;
        endcase
    endfunction : addr_index

    always_comb begin
        wr_idx = addr_index(sub_addr_i);
        rd_idx = addr_index(sub_addr_i);
        // Reserved top bit of 0x83 held at zero
        wr_val = (wr_idx == 2'h2) ? (wr_data_i & sdmc_pkg::MASK_LVL_VBI_CC) : wr_data_i; // R7
    end

    sdmc_reg_mem u_mem (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .wr_en_i(wr_i),
        .wr_idx_i(wr_idx),
        .wr_data_i(wr_val),
        .rd_idx_i(rd_idx),
        .rd_data_o(mem_rd),
        .all_o(regs)
    );

    assign r0 = regs[7:0];
    assign r2 = regs[15:8];
    assign r3 = regs[23:16];

    always_comb begin
        next_state = state;
        next_state.rd_valid = rd_i;
        next_state.cfg.standard = r0[sdmc_pkg::POS_STANDARD +: 2];
        next_state.cfg.luma_filter = r0[sdmc_pkg::POS_LUMA_FILT +: 3];
        next_state.cfg.chroma_filter = r0[sdmc_pkg::POS_CHROMA_FILT +: 3];
        next_state.cfg.prpb_antialias = r2[sdmc_pkg::POS_PRPB_AAF];
        next_state.cfg.dac_out1 = r2[sdmc_pkg::POS_DAC_OUT1];
        next_state.cfg.dac_out2 = r2[sdmc_pkg::POS_DAC_OUT2];
        next_state.cfg.composite_setup_offset = r2[sdmc_pkg::POS_SETUP];
        next_state.cfg.square_pixel = r2[sdmc_pkg::POS_SQUARE_PIX]; // R4
        next_state.cfg.tape_trick_play_sync = r2[sdmc_pkg::POS_TRICK_SYNC];
        next_state.cfg.pixel_valid_en = r2[sdmc_pkg::POS_PIX_VALID]; // R5
        next_state.cfg.edge_ctrl_en = r2[sdmc_pkg::POS_EDGE_CTRL]; // R6
        next_state.cfg.yprpb_pedestal = r3[sdmc_pkg::POS_YPRPB_PED]; // R2
        next_state.cfg.y_level_714 = r3[sdmc_pkg::POS_Y_LEVEL];
        next_state.cfg.prpb_level = r3[sdmc_pkg::POS_PRPB_LEVEL +: 2];
        // Default swing follows the colour standard
        case (r3[sdmc_pkg::POS_PRPB_LEVEL +: 2])
            sdmc_pkg::LVL_BY_STD: next_state.cfg.prpb_swing_1000 =
                (r0[sdmc_pkg::POS_STANDARD +: 2] == sdmc_pkg::STD_NTSC); // R3
            sdmc_pkg::LVL_1000: next_state.cfg.prpb_swing_1000 = 1'b1; // R3
            default: next_state.cfg.prpb_swing_1000 = 1'b0; // R3
        endcase
        next_state.cfg.blanking_interval_passthrough = r3[sdmc_pkg::POS_VBI_PASS];
        case (r3[sdmc_pkg::POS_CC_FIELD +: 2])
            sdmc_pkg::CC_ODD: next_state.cfg.caption_insert = field_odd_i; // R1
            sdmc_pkg::CC_EVEN: next_state.cfg.caption_insert = !field_odd_i; // R1
            sdmc_pkg::CC_BOTH: next_state.cfg.caption_insert = 1'b1; // R1
            default: next_state.cfg.caption_insert = 1'b0; // R1
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rd_data_o = mem_rd;
    assign rd_valid_o = state.rd_valid;
    assign cfg_o = state.cfg;
endmodule : sdmc_regs

// *** testbench/sdmc_regs_checker.sv ***
// Checker for the SD mode register bank, on the top module's ports.
// Assumes one clock, async active-high reset.
`timescale 1ns/10ps
module sdmc_regs_checker (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] sub_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i,
    input wire sdmc_pkg::sdmc_cfg_t cfg_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic w82;
    logic w83;
    assign w82 = wr_i && (sub_addr_i == sdmc_pkg::ADDR_OUT_OPTION);
    assign w83 = wr_i && (sub_addr_i == sdmc_pkg::ADDR_LVL_VBI_CC);
    // Odd/even codes depend on field timing, so only off and both here
    a_caption_gate: assert property (w83 && wr_data_i[6] == wr_data_i[5] |->
        ##2 cfg_o.caption_insert == $past(wr_data_i[5], 2)) else $error("caption gate");
    a_pedestal_bit: assert property (w83 |-> ##2 cfg_o.yprpb_pedestal == $past(wr_data_i[0], 2))
        else $error("pedestal");
    a_swing_code: assert property (w83 |-> ##2 cfg_o.prpb_level == $past(wr_data_i[3:2], 2))
        else $error("swing code");
    a_square_pixel: assert property (w82 |-> ##2 cfg_o.square_pixel == $past(wr_data_i[4], 2))
        else $error("square pixel");
    a_pixel_valid: assert property (w82 |-> ##2 cfg_o.pixel_valid_en == $past(wr_data_i[6], 2))
        else $error("pixel valid");
    a_edge_ctrl: assert property (w82 |-> ##2 cfg_o.edge_ctrl_en == $past(wr_data_i[7], 2))
        else $error("edge ctrl");
    // Fixed codes 01 and 10 need no standard: swing follows the upper code bit
    a_swing_fixed: assert property (w83 && wr_data_i[3] != wr_data_i[2] |->
        ##2 cfg_o.prpb_swing_1000 == $past(wr_data_i[3], 2)) else $error("swing fixed");
endmodule : sdmc_regs_checker
bind sdmc_regs sdmc_regs_checker u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sub_addr_i(sub_addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .cfg_o(cfg_o));

// *** testbench/sd_mode_config_registers_test.sv ***
// Bench for the SD mode register bank.
// Assumes the strobe protocol of sdmc_regs; no partner model.
`timescale 1ns/10ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_total++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module sd_mode_config_registers_test;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] sub_addr_i = 8'h00;
    logic [7:0] wr_data_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic field_odd_i = 1'b0;
    logic [7:0] rd_data_o;
    logic rd_valid_o;
    sdmc_pkg::sdmc_cfg_t cfg_o;
    int err_total = 0;
    int num_checks = 0;
    sdmc_regs dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sub_addr_i(sub_addr_i), .wr_data_i(wr_data_i),
        .wr_i(wr_i), .rd_i(rd_i), .field_odd_i(field_odd_i), .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o), .cfg_o(cfg_o));
    initial begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    // Returns once cfg_o carries the new value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        wr_i <= 1'b1;
        sub_addr_i <= a;
        wr_data_i <= d;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        rd_i <= 1'b1;
        sub_addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        `CHK("rd_valid", 1'b1, rd_valid_o)
        `CHK("rd_data", e, rd_data_o)
    endtask : rd
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        #2000000;
        err_total++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(8'h80, 8'h10);
        rd(8'h82, 8'h0B);
        rd(8'h83, 8'h04);
        rd(8'h81, 8'h00);
        `CHK("std_reset", 8'h10, {cfg_o.chroma_filter, cfg_o.luma_filter, cfg_o.standard})
        `CHK("swing_reset", 1'b0, cfg_o.prpb_swing_1000)
        `CHK("pix_valid", 1'b0, cfg_o.pixel_valid_en)
        $display("test reset done");
        wr(8'h82, 8'hD0);
        `CHK("square", 1'b1, cfg_o.square_pixel)
        `CHK("pix_valid", 1'b1, cfg_o.pixel_valid_en)
        `CHK("edge", 1'b1, cfg_o.edge_ctrl_en)
        rd(8'h82, 8'hD0);
        wr(8'h82, 8'h2F);
        `CHK("opt_off", 3'h0, {cfg_o.square_pixel, cfg_o.pixel_valid_en, cfg_o.edge_ctrl_en})
        `CHK("opt_low", 5'h1F, {cfg_o.prpb_antialias, cfg_o.dac_out1, cfg_o.dac_out2,
            cfg_o.composite_setup_offset, cfg_o.tape_trick_play_sync})
        wr(8'h83, 8'h7F);
        rd(8'h83, 8'h7F);
        `CHK("y_vbi", 2'h3, {cfg_o.y_level_714, cfg_o.blanking_interval_passthrough})
        `CHK("pedestal", 1'b1, cfg_o.yprpb_pedestal)
        $display("test options done");
        // Same code drives caption and swing fields to save writes
        for (int c = 0; c < 4; c++) begin
            wr(8'h83, {1'b0, c[1:0], 1'b0, c[1:0], 2'h0});
            `CHK("swing", c[1:0], cfg_o.prpb_level)
            `CHK("pedestal", 1'b0, cfg_o.yprpb_pedestal)
            // Standard is still NTSC here, so code 00 gives the wide swing
            `CHK("swing_1000", ~c[0], cfg_o.prpb_swing_1000)
            for (int f = 0; f < 2; f++) begin
                @(posedge ref_clk_i);
                field_odd_i <= f[0];
                repeat (2) @(posedge ref_clk_i);
                #1;
                `CHK("caption", f[0] ? c[0] : c[1], cfg_o.caption_insert)
            end
        end
        $display("test caption done");
        wr(8'h80, 8'h6D);
        rd(8'h80, 8'h6D);
        `CHK("std_fields", 8'h6D, {cfg_o.chroma_filter, cfg_o.luma_filter, cfg_o.standard})
        wr(8'h83, 8'h00);
        `CHK("swing_pal", 1'b0, cfg_o.prpb_swing_1000)
        // Unmapped write must leave the bank alone
        wr(8'h81, 8'hAA);
        rd(8'h81, 8'h00);
        rd(8'h80, 8'h6D);
        $display("test standard done");
        finish_test();
    end
endmodule : sd_mode_config_registers_test
